// File: common/ics_defines.svh
// Offsets, field positions, reset values and bit counts of the clock-stretch block
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH

`define ICS_PADDR_W      12
`define ICS_OFF_CTRL     12'h000
`define ICS_OFF_ADDR     12'h004
`define ICS_OFF_STAT     12'h008

`define ICS_CTRL_CKP     0
`define ICS_CTRL_SEN     1
`define ICS_CTRL_ADDRESS_HOLD_ENABLE    2
`define ICS_CTRL_DATA_HOLD_ENABLE    3
`define ICS_CTRL_TEN     4

`define ICS_STAT_UA      0
`define ICS_STAT_RW      1
`define ICS_STAT_HOLD    2
`define ICS_STAT_MATCH   3

`define ICS_ADDR_W       10
`define ICS_CKP_RST      1'b1
`define ICS_UA_RST       1'b0
`define ICS_ADDR_RST     10'h000
`define ICS_TEN_PREFIX   5'h1e
`define ICS_CNT_ZERO     4'h0
`define ICS_CNT_LAST     4'h8
`define ICS_CNT_ACK      4'h9

`endif

// File: common/ics_pkg.sv
// Types shared by the clock-stretch block
package ics_pkg;

	// Configuration word handed to the link domain
	typedef struct packed {
		logic       stretch_enable;
		logic       address_hold_enable;
		logic       data_hold_enable;
		logic       ten_bit;
		logic [9:0] addr;
	} ics_cfg_s;

	// Byte position in the bus transfer
	typedef enum logic [2:0] {
		ICS_IDLE,
		ICS_ADDR_HI,
		ICS_ADDR_LO,
		ICS_DATA,
		ICS_IGNORE
	} ics_state_e;

endpackage

// File: hdl/ics_stretch.sv
// Slave-side clock stretching for a two-wire serial port, APB registers
// Contract
// - Release bit cleared: wait for clock line low, then hold it low.
// - Setting the release bit stops holding the clock line.
// - After acknowledge of a read request, hardware clears the release bit.
// - With stretch enable, stretch after every acknowledge until software releases.
// - Stretching ignores buffer-full state; read requests always clear the bit.
// - Ten-bit mode: update flag stretches clock, release bit left set; here stretch enable also clears it after the low address acknowledge.
// - Writing the slave address register ends the update-flag stretch at once.
// - Address hold: clear release bit after eighth falling edge of matching address.
// - Data hold: clear release bit after eighth falling edge of received data.
// - Never pull the clock low before it has been sampled low.
// - Clock stays low until released here and by every other party.
`timescale 1ns/1ps
`include "ics_defines.svh"
module ics_stretch (
	// APB clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic [`ICS_PADDR_W-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Link clock
	input  wire logic                    link_clk,
	// Serial bus pins
	input  wire logic                    scl_i,
	output logic                         scl_o,
	output logic                         scl_oe,
	input  wire logic                    sda_i
);

	// APB decode
	wire        setup    = psel & ~penable;
	wire        access   = psel & penable;
	wire        sel_ctrl = (paddr == `ICS_OFF_CTRL);
	wire        sel_addr = (paddr == `ICS_OFF_ADDR);
	wire        sel_stat = (paddr == `ICS_OFF_STAT);
	wire        mapped   = sel_ctrl | sel_addr | sel_stat;
	wire        wr_ctrl  = access & pwrite & sel_ctrl;
	wire        wr_addr  = access & pwrite & sel_addr;

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// Register state
	logic                 ckp_ff;
	logic                 ua_ff;
	logic                 hold_ff;
	ics_pkg::ics_cfg_s    cfg_ff;
	logic                 cfg_tgl_ff;
	logic                 ack_tgl_ff;
	logic [1:0]           ev_d_ff;
	logic [31:0]          prdata_ff;

	// Link-to-register crossings
	logic [1:0]           ev_q;
	logic [2:0]           stat_q;
	logic                 clr_tgl_ff;
	logic                 ua_tgl_ff;
	logic                 scl_oe_ff;
	logic                 rw_ff;
	logic                 match_ff;

	ics_sync #(.W(5)) u_up_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({match_ff, rw_ff, scl_oe_ff, ua_tgl_ff, clr_tgl_ff}),
		.q     ({stat_q, ev_q})
	);

	wire clr_ev = ev_q[0] ^ ev_d_ff[0];
	wire ua_ev  = ev_q[1] ^ ev_d_ff[1];

	// Hardware clear beats a software set in the same cycle
	wire nxt_ckp = clr_ev ? 1'b0 :
		wr_ctrl ? pwdata[`ICS_CTRL_CKP] : ckp_ff;
	// Update flag: set wins over the clearing address write
	wire nxt_ua  = ua_ev ? 1'b1 : (wr_addr ? 1'b0 : ua_ff);
	wire nxt_hold = ~nxt_ckp | nxt_ua;

	ics_pkg::ics_cfg_s nxt_cfg;
	always_comb begin
		nxt_cfg = cfg_ff;
		if (wr_ctrl) begin
			nxt_cfg.stretch_enable     = pwdata[`ICS_CTRL_SEN];
			nxt_cfg.address_hold_enable    = pwdata[`ICS_CTRL_ADDRESS_HOLD_ENABLE];
			nxt_cfg.data_hold_enable    = pwdata[`ICS_CTRL_DATA_HOLD_ENABLE];
			nxt_cfg.ten_bit = pwdata[`ICS_CTRL_TEN];
		end
		if (wr_addr) begin
			nxt_cfg.addr = pwdata[`ICS_ADDR_W-1:0];
		end
	end

	// Read mux, captured in the setup phase
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_word[`ICS_CTRL_CKP]  = ckp_ff;
			rd_word[`ICS_CTRL_SEN]  = cfg_ff.stretch_enable;
			rd_word[`ICS_CTRL_ADDRESS_HOLD_ENABLE] = cfg_ff.address_hold_enable;
			rd_word[`ICS_CTRL_DATA_HOLD_ENABLE] = cfg_ff.data_hold_enable;
			rd_word[`ICS_CTRL_TEN]  = cfg_ff.ten_bit;
		end
		if (sel_addr) begin
			rd_word[`ICS_ADDR_W-1:0] = cfg_ff.addr;
		end
		if (sel_stat) begin
			rd_word[`ICS_STAT_UA]    = ua_ff;
			rd_word[`ICS_STAT_RW]    = stat_q[1];
			rd_word[`ICS_STAT_HOLD]  = stat_q[0];
			rd_word[`ICS_STAT_MATCH] = stat_q[2];
		end
	end

	wire nxt_cfg_tgl = cfg_tgl_ff ^ (wr_ctrl | wr_addr);
	wire nxt_ack_tgl = ack_tgl_ff ^ (clr_ev | ua_ev);
	wire [31:0] nxt_prdata = setup ? rd_word : prdata_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ckp_ff     <= `ICS_CKP_RST;
			ua_ff      <= `ICS_UA_RST;
			hold_ff    <= 1'b0;
			cfg_ff     <= '{stretch_enable: 1'b0, address_hold_enable: 1'b0, data_hold_enable: 1'b0, ten_bit: 1'b0,
				addr: `ICS_ADDR_RST};
			cfg_tgl_ff <= 1'b0;
			ack_tgl_ff <= 1'b0;
			ev_d_ff    <= 2'h0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			ckp_ff     <= nxt_ckp;
			ua_ff      <= nxt_ua;
			hold_ff    <= nxt_hold;
			cfg_ff     <= nxt_cfg;
			cfg_tgl_ff <= nxt_cfg_tgl;
			ack_tgl_ff <= nxt_ack_tgl;
			ev_d_ff    <= ev_q;
			prdata_ff  <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;

	// Link domain reset: asserted at once, released on link clock
	logic link_rst_n;
	ics_sync #(.W(1)) u_rst_sync (
		.clk   (link_clk),
		.rst_n (presetn),
		.d     (1'b1),
		.q     (link_rst_n)
	);

	// Pins and control into link domain
	logic [1:0] pin_q;
	logic [2:0] ctl_q;
	ics_sync #(.W(5)) u_dn_sync (
		.clk   (link_clk),
		.rst_n (link_rst_n),
		.d     ({ack_tgl_ff, cfg_tgl_ff, hold_ff, sda_i, scl_i}),
		.q     ({ctl_q, pin_q})
	);

	wire scl_s = pin_q[0];
	wire sda_s = pin_q[1];

	// Link state
	ics_pkg::ics_state_e state_ff;
	logic [3:0]          rcnt_ff;
	logic [7:0]          shift_ff;
	logic                scl_d_ff;
	logic                sda_d_ff;
	logic                cfg_d_ff;
	logic                ack_d_ff;
	logic                ack_dd_ff;
	logic                pend_ff;
	ics_pkg::ics_cfg_s   lcfg_ff;

	wire scl_rise = scl_s & ~scl_d_ff;
	wire scl_fall = ~scl_s & scl_d_ff;
	wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire at8      = scl_fall & (rcnt_ff == `ICS_CNT_LAST);
	wire at9      = scl_fall & (rcnt_ff == `ICS_CNT_ACK);
	wire cfg_new  = ctl_q[1] ^ cfg_d_ff;
	wire ack_edge = ack_d_ff ^ ack_dd_ff;

	// Address comparison
	wire hi_match = lcfg_ff.ten_bit ?
		((shift_ff[7:3] == `ICS_TEN_PREFIX) && (shift_ff[2:1] == lcfg_ff.addr[9:8])) :
		(shift_ff[7:1] == lcfg_ff.addr[6:0]);
	wire lo_match = (shift_ff == lcfg_ff.addr[7:0]);

	ics_pkg::ics_state_e nxt_state;
	logic [3:0]          nxt_rcnt;
	logic [7:0]          nxt_shift;
	logic                nxt_rw;
	logic                nxt_match;
	logic                clr_now;
	logic                ua_now;

	// Byte tracking; buffer-full state never takes part in the decision
	always_comb begin
		nxt_state = state_ff;
		nxt_rcnt  = rcnt_ff;
		nxt_shift = shift_ff;
		nxt_rw    = rw_ff;
		nxt_match = match_ff;
		clr_now   = 1'b0;
		ua_now    = 1'b0;
		if (start_c) begin
			nxt_state = ics_pkg::ICS_ADDR_HI;
			nxt_rcnt  = `ICS_CNT_ZERO;
		end else if (stop_c) begin
			nxt_state = ics_pkg::ICS_IDLE;
			nxt_rcnt  = `ICS_CNT_ZERO;
			nxt_match = 1'b0;
		end else begin
			if (scl_rise && (rcnt_ff < `ICS_CNT_LAST)) begin
				nxt_shift = {shift_ff[6:0], sda_s};
			end
			if (scl_rise && (rcnt_ff < `ICS_CNT_ACK)) begin
				nxt_rcnt = rcnt_ff + 4'h1;
			end
			if (at9) begin
				nxt_rcnt = `ICS_CNT_ZERO;
			end
			case (state_ff)
				ics_pkg::ICS_ADDR_HI: begin
					if (at8) begin
						nxt_rw  = shift_ff[0];
						clr_now = hi_match & lcfg_ff.address_hold_enable;
					end
					if (at9) begin
						if (!hi_match) begin
							nxt_state = ics_pkg::ICS_IGNORE;
							nxt_match = 1'b0;
						end else if (!lcfg_ff.ten_bit) begin
							nxt_state = ics_pkg::ICS_DATA;
							nxt_match = 1'b1;
							clr_now   = shift_ff[0] | lcfg_ff.stretch_enable;
						end else if (shift_ff[0]) begin
							nxt_state = match_ff ? ics_pkg::ICS_DATA : ics_pkg::ICS_IGNORE;
							clr_now   = match_ff;
						end else begin
							nxt_state = ics_pkg::ICS_ADDR_LO;
							ua_now    = 1'b1;
						end
					end
				end
				ics_pkg::ICS_ADDR_LO: begin
					if (at8) begin
						clr_now = lo_match & lcfg_ff.address_hold_enable;
					end
					if (at9) begin
						if (lo_match) begin
							nxt_state = ics_pkg::ICS_DATA;
							nxt_match = 1'b1;
							ua_now    = 1'b1;
							clr_now   = lcfg_ff.stretch_enable;
						end else begin
							nxt_state = ics_pkg::ICS_IGNORE;
							nxt_match = 1'b0;
						end
					end
				end
				ics_pkg::ICS_DATA: begin
					if (at8) begin
						clr_now = lcfg_ff.data_hold_enable & ~rw_ff;
					end
					if (at9) begin
						clr_now = lcfg_ff.stretch_enable;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Local hold bridges the crossing delay until the register side answers
	wire nxt_pend   = (clr_now | ua_now) ? 1'b1 : (ack_edge ? 1'b0 : pend_ff);
	wire hold_eff   = pend_ff | ctl_q[0];
	// Pull low only once seen low; let go as soon as released here
	wire nxt_scl_oe = hold_eff & (scl_oe_ff | ~scl_s);
	wire nxt_clr_tgl = clr_tgl_ff ^ clr_now;
	wire nxt_ua_tgl  = ua_tgl_ff ^ ua_now;
	wire ics_pkg::ics_cfg_s nxt_lcfg = cfg_new ? cfg_ff : lcfg_ff;

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_ff   <= ics_pkg::ICS_IDLE;
			rcnt_ff    <= `ICS_CNT_ZERO;
			shift_ff   <= 8'h00;
			rw_ff      <= 1'b0;
			match_ff   <= 1'b0;
			scl_d_ff   <= 1'b1;
			sda_d_ff   <= 1'b1;
			cfg_d_ff   <= 1'b0;
			ack_d_ff   <= 1'b0;
			ack_dd_ff  <= 1'b0;
			pend_ff    <= 1'b0;
			scl_oe_ff  <= 1'b0;
			clr_tgl_ff <= 1'b0;
			ua_tgl_ff  <= 1'b0;
			lcfg_ff    <= '{stretch_enable: 1'b0, address_hold_enable: 1'b0, data_hold_enable: 1'b0, ten_bit: 1'b0,
				addr: `ICS_ADDR_RST};
		end else begin
			state_ff   <= nxt_state;
			rcnt_ff    <= nxt_rcnt;
			shift_ff   <= nxt_shift;
			rw_ff      <= nxt_rw;
			match_ff   <= nxt_match;
			scl_d_ff   <= scl_s;
			sda_d_ff   <= sda_s;
			cfg_d_ff   <= ctl_q[1];
			ack_d_ff   <= ctl_q[2];
			ack_dd_ff  <= ack_d_ff;
			pend_ff    <= nxt_pend;
			scl_oe_ff  <= nxt_scl_oe;
			clr_tgl_ff <= nxt_clr_tgl;
			ua_tgl_ff  <= nxt_ua_tgl;
			lcfg_ff    <= nxt_lcfg;
		end
	end

	// Open drain: only ever low
	assign scl_o  = 1'b0;
	assign scl_oe = scl_oe_ff;

endmodule

// File: hdl/ics_sync.sv
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module ics_sync #(
	parameter int W = 1
) (
	// Destination clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_ff;
			logic sync_ff;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_ff <= 1'b0;
					sync_ff <= 1'b0;
				end else begin
					meta_ff <= d[i];
					sync_ff <= meta_ff;
				end
			end
			assign q[i] = sync_ff;
		end
	endgenerate

endmodule

// File: tb/ics_i2c_master.sv
// Behavioural bus master that waits out clock stretching
`timescale 1ns/1ps
module ics_i2c_master (
	// Timing clock
	input wire logic pclk,
	// Bus levels
	input wire logic scl,
	output logic     scl_oe,
	output logic     sda_oe
);
	localparam int H = 12;

	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Let the clock rise and wait while anyone holds it
	task automatic rise();
		scl_oe <= 1'b0;
		hw(1);
		while (!scl) @(posedge pclk);
		hw(H);
	endtask

	task automatic start();
		sda_oe <= 1'b1;
		hw(H);
		scl_oe <= 1'b1;
		hw(H);
	endtask

	task automatic bit1(input logic v);
		sda_oe <= !v;
		hw(H);
		rise();
		scl_oe <= 1'b1;
	endtask

	task automatic stop();
		sda_oe <= 1'b1;
		hw(H);
		rise();
		sda_oe <= 1'b0;
		hw(H);
	endtask
endmodule

// File: tb/ics_monitor.sv
// Port checker for the clock-stretch block
`timescale 1ns/1ps
module ics_monitor (
	// Clocks and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        link_clk,
	// APB
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Serial pins
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_i
);
	logic [5:0] wcnt_ff;
	logic       ckp_ff;
	wire        acc = psel && penable && pwrite;
	wire        rel_wr = acc && (paddr == 12'h004 || (paddr == 12'h000 && pwdata[0]));
	wire        bad = paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008;

	// Cycles since the last software release, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt_ff <= 6'h3f;
			ckp_ff  <= 1'b1;
		end else begin
			wcnt_ff <= rel_wr ? 6'h00 : wcnt_ff + 6'(wcnt_ff != 6'h3f);
			if (acc && paddr == 12'h000)
				ckp_ff <= pwdata[0];
		end
	end

	a_open_drain: assert property (
		@(posedge pclk) disable iff (!presetn) scl_o == 1'b0) else $error("clock driven high");
	a_no_early_pull: assert property (
		@(posedge link_clk) disable iff (!presetn) $rose(scl_oe) |-> !$past(scl_i, 3))
		else $error("clock pulled while high");
	a_hold_after_clear: assert property (
		@(posedge link_clk) disable iff (!presetn) (!ckp_ff && !scl_i) [*8] |-> scl_oe)
		else $error("cleared release bit not holding");
	a_hold_min_span: assert property (
		@(posedge link_clk) disable iff (!presetn) $rose(scl_oe) |=> scl_oe [*2])
		else $error("hold dropped early");
	a_release_cause: assert property (
		@(posedge pclk) disable iff (!presetn) $fell(scl_oe) |-> wcnt_ff < 6'd12)
		else $error("hold ended without release write");
	a_zero_wait: assert property (
		@(posedge pclk) disable iff (!presetn) psel |-> pready) else $error("pready low");
	a_err_decode: assert property (
		@(posedge pclk) disable iff (!presetn) psel && penable |-> pslverr == bad)
		else $error("pslverr decode wrong");
	a_err_rdata: assert property (
		@(posedge pclk) disable iff (!presetn) psel && penable && !pwrite && bad |-> prdata == 0)
		else $error("unmapped read not zero");

	c_hold: cover property (@(posedge link_clk) $rose(scl_oe));
	c_release: cover property (@(posedge pclk) $fell(scl_oe));
	c_err: cover property (@(posedge pclk) pslverr);
endmodule

bind ics_stretch ics_monitor u_mon (.pclk, .presetn, .link_clk, .paddr, .psel, .penable,
	.pwrite, .pwdata, .prdata, .pready, .pslverr, .scl_i, .scl_o, .scl_oe, .sda_i);

// File: tb/tb_ics_stretch.sv
// Self-checking bench for register access and stretch points
`timescale 1ns/1ps
module tb_ics_stretch;
	logic        pclk = 1'b0;
	logic        link_clk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_o;
	logic        scl_oe;
	logic        m_scl;
	logic        m_sda;
	logic [31:0] rd;
	logic        er;
	int          n_fail = 0;
	int          checks = 0;
	// Both lines pulled up
	wire         scl = !(scl_oe | m_scl);
	wire         sda = !m_sda;

	always #25 pclk = !pclk;
	always #24 link_clk = !link_clk;

	ics_stretch dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .link_clk, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda));
	ics_i2c_master m (.pclk, .scl, .scl_oe(m_scl), .sda_oe(m_sda));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask

	task automatic wait_oe(input logic v);
		int i;
		i = 0;
		while (scl_oe !== v && i < 12) begin
			@(posedge pclk);
			i++;
		end
		cmp({31'h0, scl_oe}, {31'h0, v});
	endtask

	task automatic cfg(input logic [31:0] c);
		apb(1'b1, 12'h000, c);
		repeat (8) @(posedge pclk);
	endtask

	task automatic hold(input logic [31:0] c);
		wait_oe(1'b1);
		// Let the hardware clear or flag cross into the register side
		repeat (4) @(posedge pclk);
		chk(12'h000, c);
		cmp({31'h0, scl_oe}, 32'h1);
	endtask

	task automatic rel(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		wait_oe(1'b0);
	endtask

	task automatic byte8(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			m.bit1(b[i]);
	endtask

	task automatic stop_test();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		stop_test();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(12'h000, 32'h1);
		chk(12'h004, 32'h0);
		chk(12'h00c, 32'h0);
		cmp({31'h0, er}, 32'h1);
		apb(1'b1, 12'h008, 32'h1);
		chk(12'h008, 32'h0);
		// Cleared release bit while idle, then a start
		cfg(32'h0);
		repeat (20) @(posedge pclk);
		cmp({31'h0, scl_oe}, 32'h0);
		m.start();
		hold(32'h0);
		rel(12'h000, 32'h1);
		m.stop();
		// Read request
		apb(1'b1, 12'h004, 32'h2a);
		cfg(32'h1);
		m.start();
		byte8(8'h55);
		m.bit1(1'b0);
		hold(32'h0);
		chk(12'h008, 32'he);
		rel(12'h000, 32'h1);
		m.stop();
		// Address hold, data hold and stretch enable
		cfg(32'hf);
		m.start();
		for (int k = 0; k < 4; k++) begin
			if (k[0])
				m.bit1(1'b0);
			else
				byte8(k != 0 ? 8'ha3 : 8'h54);
			hold(32'he);
			rel(12'h000, 32'hf);
		end
		m.stop();
		// Ten-bit address, update flag
		apb(1'b1, 12'h004, 32'h2a5);
		cfg(32'h11);
		m.start();
		for (int k = 0; k < 2; k++) begin
			byte8(k != 0 ? 8'ha5 : 8'hf4);
			m.bit1(1'b0);
			hold(32'h11);
			apb(1'b0, 12'h008, 32'h0);
			cmp(rd & 32'h1, 32'h1);
			rel(12'h004, 32'h2a5);
		end
		m.stop();
		stop_test();
	end
endmodule
